// ---- design/btss_pkg.sv ----
// Purpose : constants and types for the bit-test-skip-if-set execution block
// Assumes : 16-bit opcodes, 8-bit file registers, four-phase instruction cycle
// Notes   : used by the executor only; the operand-read module does not reference it
package btss_pkg;
	// ======================================================================
	// opcode layout
	localparam logic [3:0] OPC_TEST_SET    = 4'ha;
	localparam int         OPC_HI_POS      = 12;
	localparam int         BIT_IDX_POS     = 9;
	localparam int         BANK_SEL_POS    = 8;
	localparam int         FADDR_POS       = 0;
	// ======================================================================
	// addressing
	localparam logic [7:0] INDEXED_MAX     = 8'h5f;
	localparam logic [3:0] ACCESS_BANK_LO  = 4'h0;
	localparam logic [3:0] ACCESS_BANK_HI  = 4'hf;
	localparam logic [7:0] ACCESS_SPLIT    = 8'h60;
	// ======================================================================
	// reset values and idle counter load values
	localparam logic [3:0] PHASE_RST       = 4'h1;
	localparam logic [1:0] IDLE_CNT_RST    = 2'h0;
	localparam logic [1:0] IDLE_ONE_WORD   = 2'h1;
	localparam logic [1:0] IDLE_TWO_WORD   = 2'h2;
	// ======================================================================
	// execution states, one-hot
	typedef enum logic [2:0] {
		BTSS_ST_IDLE = 3'b001,
		BTSS_ST_TEST = 3'b010,
		BTSS_ST_SKIP = 3'b100
	} btss_state_t;
endpackage : btss_pkg

// ---- design/btss_opnd_if.sv ----
// Purpose : carries operand address and read data between executor and reader
// Assumes : one read per test cycle
// Notes   : address is 12 bits, bank in the upper nibble
`timescale 1ns/100ps
`default_nettype none
interface btss_opnd_if;
	logic        rd_req;
	logic [11:0] rd_addr;
	logic [7:0]  rd_data;
	modport exec (output rd_req, output rd_addr, input rd_data);
	modport rdr  (input rd_req, input rd_addr, output rd_data);
endinterface : btss_opnd_if
`default_nettype wire

// ---- design/btss_opnd_rd.sv ----
// Purpose : registered read of the file register selected by the executor
// Assumes : data memory answers combinationally on its read port
// Notes   : read data held in a register so phase three sees a stable byte
`timescale 1ns/100ps
`default_nettype none
module btss_opnd_rd (
	input  wire logic  i_clk,
	input  wire logic  i_sys_rst,
	input  wire logic  i_ce,
	btss_opnd_if.rdr   opnd,
	output logic       o_mem_re,
	output logic [11:0] o_mem_addr,
	input  wire logic [7:0] i_mem_rdata
);
	// ======================================================================
	// memory port passes address straight through, data is latched
	assign o_mem_re   = opnd.rd_req;
	assign o_mem_addr = opnd.rd_addr;
	logic [7:0] data_r;
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			data_r <= 8'h00;
		end else if (i_ce && opnd.rd_req) begin
			data_r <= i_mem_rdata;
		end
	end
	assign opnd.rd_data = data_r;
endmodule : btss_opnd_rd
`default_nettype wire

// ---- design/btss_exec.sv ----
// Purpose : executes the bit-test-skip-if-set instruction in the core pipeline
// Assumes : i_clk edges are the four quarter phases; i_instr valid at phase one
// Notes   : status flags are never touched; no write port exists at all
//
// Function
// - decode upper nibble 1010, bit, bank, address
// - skip next instruction when tested bit set
// - skip replaces prefetched instruction with idle cycle
// - two-word follower costs two idle cycles
// - selector zero access bank, one banked
// - bank select register supplies bank number
// - extended set, low addresses use indexed offset
`timescale 1ns/100ps
`default_nettype none
module btss_exec (
	input  wire logic        i_clk,
	input  wire logic        i_sys_rst,
	input  wire logic        i_ce,
	input  wire logic        i_instr_valid,
	input  wire logic [15:0] i_instr,
	input  wire logic        i_next_two_word,
	input  wire logic [3:0]  i_bank_select_register,
	input  wire logic        i_ext_set_en,
	input  wire logic [11:0] i_index_base,
	input  wire logic [7:0]  i_mem_rdata,
	output logic             o_mem_re,
	output logic [11:0]      o_mem_addr,
	output logic             o_busy,
	output logic             o_skip,
	output logic             o_idle_instruction,
	output logic             o_flush_prefetch,
	output logic [3:0]       o_phase,
	output logic             o_done
);
	// ======================================================================
	// decode helpers
	function automatic logic is_test_set(input logic [15:0] op);
		is_test_set = (op[btss_pkg::OPC_HI_POS +: 4] == btss_pkg::OPC_TEST_SET);
	endfunction : is_test_set

	function automatic logic [11:0] opnd_addr(input logic [15:0] op, input logic [3:0] bank_select_register,
		input logic ext, input logic [11:0] base);
		logic [7:0] f;
		f = op[btss_pkg::FADDR_POS +: 8];
		if (op[btss_pkg::BANK_SEL_POS]) begin
			opnd_addr = {bank_select_register, f};
		end else if (ext && (f <= btss_pkg::INDEXED_MAX)) begin
			opnd_addr = base + {4'h0, f};
		end else if (f < btss_pkg::ACCESS_SPLIT) begin
			opnd_addr = {btss_pkg::ACCESS_BANK_LO, f};
		end else begin
			opnd_addr = {btss_pkg::ACCESS_BANK_HI, f};
		end
	endfunction : opnd_addr

	// ======================================================================
	// phase ring and state
	btss_opnd_if opnd ();
	btss_pkg::btss_state_t state_r;
	logic [3:0]  phase_r;
	logic [15:0] instr_r;
	logic        two_word_r;
	logic [1:0]  idle_cnt_r;
	logic        skip_r;
	logic        done_r;
	logic        take_w;
	logic        test_last_w;
	logic        skip_last_w;
	logic        bit_hit_w;
	logic [7:0]  lane_hit_w;

	// a quarter-phase ring; every instruction cycle is four clocks
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			phase_r <= btss_pkg::PHASE_RST;
		end else if (i_ce) begin
			phase_r <= {phase_r[2:0], phase_r[3]};
		end
	end

	// ======================================================================
	// instruction strobes
	// opcode nibble gates take
	assign take_w      = (state_r == btss_pkg::BTSS_ST_IDLE) && phase_r[0]
		&& i_instr_valid && is_test_set(i_instr);
	assign test_last_w = (state_r == btss_pkg::BTSS_ST_TEST) && phase_r[3];
	assign skip_last_w = (state_r == btss_pkg::BTSS_ST_SKIP) && phase_r[3]
		&& (idle_cnt_r == btss_pkg::IDLE_ONE_WORD);

	// ======================================================================
	// bit lanes
	// one lane per bit position; only the indexed lane can fire
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_lane
			assign lane_hit_w[g] = opnd.rd_data[g] && (instr_r[btss_pkg::BIT_IDX_POS +: 3] == 3'(g));
		end
	endgenerate
	assign bit_hit_w = |lane_hit_w;

	// ======================================================================
	// state register
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state_r <= btss_pkg::BTSS_ST_IDLE;
		end else if (i_ce) begin
			case (state_r)
				btss_pkg::BTSS_ST_IDLE: begin
					if (take_w) begin
						state_r <= btss_pkg::BTSS_ST_TEST;
					end
				end
				btss_pkg::BTSS_ST_TEST: begin
					if (phase_r[3]) begin
						state_r <= skip_r ? btss_pkg::BTSS_ST_SKIP : btss_pkg::BTSS_ST_IDLE;
					end
				end
				btss_pkg::BTSS_ST_SKIP: begin
					if (skip_last_w) begin
						state_r <= btss_pkg::BTSS_ST_IDLE;
					end
				end
				default: begin
					state_r <= btss_pkg::BTSS_ST_IDLE;
				end
			endcase
		end
	end

	// ======================================================================
	// opcode capture
	// held for the whole instruction so the operand address stays put
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			instr_r    <= 16'h0000;
			two_word_r <= 1'b0;
		end else if (i_ce && take_w) begin
			instr_r    <= i_instr;
			two_word_r <= i_next_two_word;
		end
	end

	// ======================================================================
	// skip flag
	// loaded at phase three so phase four already knows the outcome
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			skip_r <= 1'b0;
		end else if (i_ce) begin
			if ((state_r == btss_pkg::BTSS_ST_TEST) && phase_r[2]) begin
				skip_r <= bit_hit_w;
			end else if ((state_r == btss_pkg::BTSS_ST_IDLE) || skip_last_w) begin
				skip_r <= 1'b0;
			end
		end
	end

	// ======================================================================
	// idle cycle counter
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			idle_cnt_r <= btss_pkg::IDLE_CNT_RST;
		end else if (i_ce) begin
			if ((state_r == btss_pkg::BTSS_ST_TEST) && phase_r[2] && bit_hit_w) begin
				// two idle cycles for two words
				idle_cnt_r <= two_word_r ? btss_pkg::IDLE_TWO_WORD : btss_pkg::IDLE_ONE_WORD;
			end else if ((state_r == btss_pkg::BTSS_ST_SKIP) && phase_r[3]) begin
				idle_cnt_r <= idle_cnt_r - 2'h1;
			end
		end
	end

	// ======================================================================
	// end-of-instruction pulse, registered
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			done_r <= 1'b0;
		end else if (i_ce) begin
			done_r <= (test_last_w && !skip_r) || skip_last_w;
		end
	end

	// ======================================================================
	// operand read
	// read file register in phase two
	assign opnd.rd_req  = (state_r == btss_pkg::BTSS_ST_TEST) && phase_r[1];
	assign opnd.rd_addr = opnd_addr(instr_r, i_bank_select_register, i_ext_set_en, i_index_base);

	btss_opnd_rd u_rd (
		.i_clk       (i_clk),
		.i_sys_rst   (i_sys_rst),
		.i_ce        (i_ce),
		.opnd        (opnd.rdr),
		.o_mem_re    (o_mem_re),
		.o_mem_addr  (o_mem_addr),
		.i_mem_rdata (i_mem_rdata)
	);

	// ======================================================================
	// outputs
	assign o_busy             = (state_r != btss_pkg::BTSS_ST_IDLE);
	assign o_skip             = skip_r;
	assign o_idle_instruction = (state_r == btss_pkg::BTSS_ST_SKIP);
	assign o_flush_prefetch   = (state_r == btss_pkg::BTSS_ST_TEST) && phase_r[3] && skip_r;
	assign o_phase            = phase_r;
	assign o_done             = done_r;
endmodule : btss_exec
`default_nettype wire

// ---- test/btss_exec_asserts.sv ----
// Purpose: port timing checks for the skip-if-set executor
// Assumes: one-hot phase ring, four clocks per instruction cycle
// Notes: bound from the bench top file
`timescale 1ns/100ps
`default_nettype none
module btss_exec_asserts (
	input wire logic       i_clk,
	input wire logic       i_sys_rst,
	input wire logic       i_ce,
	input wire logic       o_mem_re,
	input wire logic       o_busy,
	input wire logic       o_skip,
	input wire logic       o_idle_instruction,
	input wire logic       o_flush_prefetch,
	input wire logic [3:0] o_phase,
	input wire logic       o_done
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	logic [3:0] idle_cnt_r;
	// idle clocks since flush, judged when idle ends
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) idle_cnt_r <= 4'h0;
		else if (o_flush_prefetch) idle_cnt_r <= 4'h0;
		else if (o_idle_instruction && i_ce) idle_cnt_r <= idle_cnt_r + 4'h1;
	end
	sequence idle_cyc; o_idle_instruction [*4]; endsequence
	phase_ring_a: assert property (i_ce |=> o_phase == {$past(o_phase[2:0]), $past(o_phase[3])})
		else $error("phase ring broken");
	read_phase_a: assert property (o_mem_re |-> o_phase == 4'h2 && o_busy)
		else $error("read outside phase two");
	flush_phase_a: assert property (o_flush_prefetch |-> o_phase == 4'h8 && o_skip)
		else $error("flush outside phase four");
	flush_idle_a: assert property (o_flush_prefetch |=> idle_cyc)
		else $error("no idle cycle after flush");
	idle_count_a: assert property ($fell(o_idle_instruction) |-> idle_cnt_r == 4'h4 || idle_cnt_r == 4'h8)
		else $error("idle length wrong");
	skip_flush_a: assert property ($rose(o_skip) |-> ##[0:2] o_flush_prefetch)
		else $error("skip without flush");
	idle_skip_a: assert property (o_idle_instruction |-> o_skip && o_busy)
		else $error("idle without skip");
	done_pulse_a: assert property (o_done |=> !o_done)
		else $error("done longer than one clock");
	freeze_hold_a: assert property (!i_ce |=> $stable(o_phase) && $stable(o_busy))
		else $error("state moved while clock enable low");
endmodule : btss_exec_asserts
`default_nettype wire

// ---- test/test_bit_test_skip_if_set_exec.sv ----
// Purpose: self-checking bench for the skip-if-set executor
// Assumes: memory answers with its own address low byte
// Notes: bit b set in data exactly when set in f
`timescale 1ns/100ps
`default_nettype none
module test_bit_test_skip_if_set_exec;
	logic clk = 0, rst = 1, vld = 0, two = 0, ext = 0, ce = 1, re, busy, skp, idl, fl, dn;
	logic [15:0] ins = 16'h0000;
	logic [3:0] bank_select_register = 4'h5, ph;
	logic [11:0] addr;
	int mismatches = 0, checks = 0;
	btss_exec u_btss_exec (.i_clk(clk), .i_sys_rst(rst), .i_ce(ce), .i_instr_valid(vld), .i_instr(ins),
		.i_next_two_word(two), .i_bank_select_register(bank_select_register), .i_ext_set_en(ext), .i_index_base(12'h0100),
		.i_mem_rdata(addr[7:0]), .o_mem_re(re), .o_mem_addr(addr), .o_busy(busy), .o_skip(skp),
		.o_idle_instruction(idl), .o_flush_prefetch(fl), .o_phase(ph), .o_done(dn));
	task finish_test;
		if (mismatches == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : finish_test
	task cmp(input logic [11:0] got, input logic [11:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	// one instruction: bit, bank sel, address, two-word, expected address, idle clocks, reads
	task run(input logic [2:0] b, input logic a, input logic [7:0] f, input logic tw,
		input logic [11:0] ea, input logic [3:0] ei, input logic [3:0] er, input logic [3:0] op = 4'ha);
		logic [11:0] ga;
		logic [3:0] gi, gr, gf, gs;
		ga = 12'h000; gi = 4'h0; gr = 4'h0;
		gf = 4'h0;
		gs = 4'h0;
		for (int n = 0; n < 20 && !(ph === 4'h1 && busy === 1'b0); n++) @(negedge clk);
		vld = 1; ins = {op, b, a, f}; two = tw;
		@(negedge clk) vld = 0;
		for (int n = 0; n < 24 && dn !== 1'b1; n++) begin
			if (re === 1'b1) begin ga = addr; gr++; end
			if (idl === 1'b1) gi++;
			if (fl === 1'b1) gf++;
			if (skp === 1'b1) gs++;
			@(negedge clk);
		end
		cmp(ga, ea);
		cmp({8'h00, gi}, {8'h00, ei});
		cmp({8'h00, gr}, {8'h00, er});
		cmp({8'h00, gf}, {11'h000, ei != 4'h0});
		cmp({8'h00, gs}, {8'h00, (ei == 4'h0) ? 4'h0 : ei + 4'h1});
		cmp({11'h000, dn}, {11'h000, er != 4'h0});
		if (er != 4'h0) cmp({8'h00, ph}, 12'h001);
	endtask : run
	task s_access;
		// skip, one word; access bank low half
		run(3'd1, 1'b0, 8'h12, 1'b0, 12'h012, 4'h4, 4'h1);
		// boundary 60h lands high; two-word follower
		run(3'd5, 1'b0, 8'h60, 1'b1, 12'hf60, 4'h8, 4'h1);
		run(3'd0, 1'b0, 8'h80, 1'b1, 12'hf80, 4'h0, 4'h1);
	endtask : s_access
	task s_banked;
		run(3'd7, 1'b1, 8'h5a, 1'b0, 12'h55a, 4'h0, 4'h1);
		run(3'd7, 1'b1, 8'hda, 1'b1, 12'h5da, 4'h8, 4'h1);
	endtask : s_banked
	task s_indexed;
		ext = 1;
		run(3'd6, 1'b0, 8'h5f, 1'b0, 12'h15f, 4'h4, 4'h1);
		run(3'd5, 1'b0, 8'h60, 1'b0, 12'hf60, 4'h4, 4'h1);
		ext = 0;
		// clear-variant opcode must be ignored
		run(3'd1, 1'b0, 8'h02, 1'b0, 12'h000, 4'h0, 4'h0, 4'hb);
	endtask : s_indexed
	// clock enable low: opcode not taken, phase held; then a normal skip
	task s_freeze;
		logic [3:0] p0;
		p0 = 4'h0;
		for (int n = 0; n < 20 && !(ph === 4'h1 && busy === 1'b0); n++) @(negedge clk);
		ce = 0;
		vld = 1;
		ins = 16'ha212;
		two = 0;
		p0 = ph;
		repeat (3) @(negedge clk);
		cmp({8'h00, ph}, {8'h00, p0});
		cmp({11'h000, busy}, 12'h000);
		ce = 1;
		@(negedge clk) vld = 0;
		for (int n = 0; n < 24 && dn !== 1'b1; n++) @(negedge clk);
		cmp({11'h000, dn}, 12'h001);
	endtask : s_freeze
	initial forever #10 clk = ~clk;
	initial begin
		#40000 mismatches++;
		finish_test;
	end
	initial begin
		repeat (6) @(negedge clk);
		rst = 0;
		s_access;
		s_banked;
		s_indexed;
		s_freeze;
		finish_test;
	end
endmodule : test_bit_test_skip_if_set_exec
bind btss_exec btss_exec_asserts u_btss_exec_asserts (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce),
	.o_mem_re(o_mem_re), .o_busy(o_busy), .o_skip(o_skip), .o_idle_instruction(o_idle_instruction),
	.o_flush_prefetch(o_flush_prefetch), .o_phase(o_phase), .o_done(o_done));
`default_nettype wire
